// ==== hdl/flash_status_pkg.sv ====
// Package: constants and carrier types for the flash status readout block
package flash_status_pkg;

    // ==========================================================
    // Command and status word layout
    // ==========================================================
    localparam logic [7:0] OPCODE_READ_STATUS = 8'hd7;
    localparam int         BYTE_BITS          = 8;
    localparam int         POS_READY          = 7;
    localparam int         POS_COMPARE        = 6;
    localparam int         POS_DENSITY_LO     = 2;
    localparam int         POS_PROTECT        = 1;
    localparam int         POS_PAGE_512       = 0;
    localparam int         POS_FAULT          = 5;
    localparam logic [2:0] RESERVED_LOW_VALUE = 3'h0;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic RESET_COMPARE = 1'h0;
    localparam logic RESET_FAULT   = 1'h0;
    localparam logic RESET_CS_N    = 1'h1;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [3:0] {
        PH_IDLE   = 4'h1,
        PH_OPCODE = 4'h2,
        PH_STATUS = 4'h4,
        PH_IGNORE = 4'h8
    } phase_type;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
    } spi_pins_type;

    typedef struct packed {
        logic busy;
        logic protect;
        logic page_512;
        logic comp_done;
        logic comp_mismatch;
        logic op_done;
        logic op_fault;
        logic op_abort;
    } core_status_type;

    typedef struct packed {
        spi_pins_type sync1;
        spi_pins_type sync2;
        spi_pins_type sync3;
        spi_pins_type lvl;
        phase_type    phase;
        logic [2:0]   bit_cnt;
        logic [7:0]   opcode;
        logic         byte_sel;
        logic [6:0]   shift;
        logic         so;
        logic         so_oe;
        logic         comp;
        logic         write_erase_fault;
    } state_type;

endpackage

// ==== hdl/flash_status_readout.sv ====
// Module: serial status-word readout of a flash device, sampled on the system clock
`timescale 1ns/1ps

module flash_status_readout #(
    // Arbitrary value; replace with the product's own capacity code
    parameter logic [3:0] DENSITY_CODE = 4'h5
) (
    input  wire logic                              i_clk_sys, // 250 MHz system clock
    input  wire logic                              i_rstn,    // Async reset, active low
    input  wire flash_status_pkg::spi_pins_type    i_spi,     // Raw pins sck, cs_n, si
    input  wire flash_status_pkg::core_status_type i_core,    // Internal engine status
    output logic                                   o_so,      // Serial data out value
    output logic                                   o_so_oe,   // Serial out drive enable
    output logic [7:0]                             o_status_byte_one, // Live byte one
    output logic [7:0]                             o_status_byte_two  // Live byte two
);

    // ==========================================================
    // State and pin filtering
    // ==========================================================
    flash_status_pkg::state_type s;
    flash_status_pkg::state_type next_s;

    logic [7:0] status_byte_one;
    logic [7:0] status_byte_two;
    logic [7:0] opcode_in;
    logic [7:0] byte_now;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;
    logic       cs_rise;
    logic       cs_high;

    // A pin change counts only once stages two and three agree
    assign sck_rise = (s.sync2.sck == s.sync3.sck) && s.sync3.sck && !s.lvl.sck;
    assign sck_fall = (s.sync2.sck == s.sync3.sck) && !s.sync3.sck && s.lvl.sck;
    assign cs_fall  = (s.sync2.cs_n == s.sync3.cs_n) && !s.sync3.cs_n && s.lvl.cs_n;
    assign cs_rise  = (s.sync2.cs_n == s.sync3.cs_n) && s.sync3.cs_n && !s.lvl.cs_n;
    assign cs_high  = s.lvl.cs_n;

    // ==========================================================
    // Status word, built every cycle from live inputs and the held compare and fault flags
    // ==========================================================
    always_comb
    begin
        status_byte_one = 8'h00;
        status_byte_one[flash_status_pkg::POS_READY]    = !i_core.busy;
        status_byte_one[flash_status_pkg::POS_COMPARE]  = s.comp;
        status_byte_one[flash_status_pkg::POS_DENSITY_LO +: 4] = DENSITY_CODE;
        status_byte_one[flash_status_pkg::POS_PROTECT]  = i_core.protect;
        status_byte_one[flash_status_pkg::POS_PAGE_512] = i_core.page_512;
        status_byte_two = 8'h00;
        status_byte_two[flash_status_pkg::POS_READY]    = !i_core.busy;
        status_byte_two[flash_status_pkg::POS_FAULT]    = s.write_erase_fault;
        status_byte_two[2:0] = flash_status_pkg::RESERVED_LOW_VALUE;
    end

    assign opcode_in = {s.opcode[6:0], s.lvl.si};
    assign byte_now  = s.byte_sel ? status_byte_two : status_byte_one;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        next_s       = s;
        next_s.sync1 = i_spi;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        if (s.sync2.sck == s.sync3.sck)
        begin
            next_s.lvl.sck = s.sync3.sck;
        end
        if (s.sync2.cs_n == s.sync3.cs_n)
        begin
            next_s.lvl.cs_n = s.sync3.cs_n;
        end
        if (s.sync2.si == s.sync3.si)
        begin
            next_s.lvl.si = s.sync3.si;
        end

        // Flags held here are set only by the internal engines, never by the link
        if (i_core.comp_done)
        begin
            next_s.comp = i_core.comp_mismatch;
        end
        // Completion wins over a simultaneous abort; an abort alone leaves it be
        if (i_core.op_done)
        begin
            next_s.write_erase_fault = i_core.op_fault;
        end

        case (s.phase)
            flash_status_pkg::PH_IDLE:
            begin
                next_s.so_oe = 1'b0;
                if (cs_fall)
                begin
                    next_s.phase   = flash_status_pkg::PH_OPCODE;
                    next_s.bit_cnt = 3'h0;
                end
            end
            flash_status_pkg::PH_OPCODE:
            begin
                if (sck_rise)
                begin
                    // Opcode arrives MSB first on the rising edge
                    next_s.opcode  = opcode_in;
                    next_s.bit_cnt = s.bit_cnt + 3'h1;
                    if (s.bit_cnt == 3'h7)
                    begin
                        // Accepted regardless of busy
                        if (opcode_in == flash_status_pkg::OPCODE_READ_STATUS)
                        begin
                            next_s.phase    = flash_status_pkg::PH_STATUS;
                            next_s.bit_cnt  = 3'h0;
                            next_s.byte_sel = 1'b0;
                        end
                        else
                        begin
                            next_s.phase = flash_status_pkg::PH_IGNORE;
                        end
                    end
                end
            end
            flash_status_pkg::PH_STATUS:
            begin
                if (sck_fall)
                begin
                    next_s.so_oe   = 1'b1;
                    next_s.bit_cnt = s.bit_cnt + 3'h1;
                    if (s.bit_cnt == 3'h0)
                    begin
                        // Load a fresh byte at each byte start
                        next_s.so    = byte_now[7];
                        next_s.shift = byte_now[6:0];
                    end
                    else
                    begin
                        next_s.so    = s.shift[6];
                        next_s.shift = {s.shift[5:0], 1'b0};
                    end
                    if (s.bit_cnt == 3'h7)
                    begin
                        next_s.byte_sel = !s.byte_sel;
                    end
                end
            end
            flash_status_pkg::PH_IGNORE:
            begin
                next_s.so_oe = 1'b0;
            end
            default:
            begin
                next_s.phase = flash_status_pkg::PH_IDLE;
                next_s.so_oe = 1'b0;
            end
        endcase

        // Select release ends any phase at any bit position
        if (cs_rise || (cs_high && s.phase != flash_status_pkg::PH_IDLE))
        begin
            next_s.phase = flash_status_pkg::PH_IDLE;
            next_s.so_oe = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s                   <= '0;
            s.phase             <= flash_status_pkg::PH_IDLE;
            s.sync1.cs_n        <= flash_status_pkg::RESET_CS_N;
            s.sync2.cs_n        <= flash_status_pkg::RESET_CS_N;
            s.sync3.cs_n        <= flash_status_pkg::RESET_CS_N;
            s.lvl.cs_n          <= flash_status_pkg::RESET_CS_N;
            s.comp              <= flash_status_pkg::RESET_COMPARE;
            s.write_erase_fault <= flash_status_pkg::RESET_FAULT;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Link offers no write path: the status bytes only leave the block
    assign o_so              = s.so;
    assign o_so_oe           = s.so_oe;
    assign o_status_byte_one = status_byte_one;
    assign o_status_byte_two = status_byte_two;

    // ==========================================================
    // Assertions
    // ==========================================================
    logic byte_start;
    assign byte_start = sck_fall && (s.phase == flash_status_pkg::PH_STATUS);

    // Byte loads while select is held; the seven bits after bit 7 wait in shift
    logic load_one;
    logic load_two;
    assign load_one = byte_start && s.bit_cnt == 3'h0 && !s.byte_sel && !cs_high && !cs_rise;
    assign load_two = byte_start && s.bit_cnt == 3'h0 && s.byte_sel && !cs_high && !cs_rise;

    chk_opcode_entry: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (s.phase == flash_status_pkg::PH_OPCODE && sck_rise && s.bit_cnt == 3'h7
         && opcode_in == flash_status_pkg::OPCODE_READ_STATUS && !cs_rise && !cs_high)
        |=> (s.phase == flash_status_pkg::PH_STATUS && s.bit_cnt == 3'h0))
        else $error("read status opcode not accepted");

    chk_busy_accept: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_core.busy && s.phase == flash_status_pkg::PH_OPCODE && sck_rise
         && s.bit_cnt == 3'h7 && opcode_in == flash_status_pkg::OPCODE_READ_STATUS
         && !cs_high && !cs_rise)
        |=> s.phase == flash_status_pkg::PH_STATUS)
        else $error("status read refused while busy");

    chk_byte_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (byte_start && s.bit_cnt == 3'h7 && !cs_high && !cs_rise)
        |=> (s.byte_sel != $past(s.byte_sel) && s.bit_cnt == 3'h0))
        else $error("status byte did not alternate");

    chk_ready_fresh: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (byte_start && s.bit_cnt == 3'h0 && !cs_high && !cs_rise)
        |=> (o_so == !$past(i_core.busy) && o_so_oe))
        else $error("ready bit not fresh at byte start");

    chk_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (byte_start && s.byte_sel && (s.bit_cnt == 3'h1 || s.bit_cnt == 3'h3
         || s.bit_cnt == 3'h4) && !cs_high && !cs_rise)
        |=> !o_so)
        else $error("reserved bit of byte two not zero");

    chk_release_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        cs_rise |=> (s.phase == flash_status_pkg::PH_IDLE && !o_so_oe))
        else $error("output still driven after select release");

    chk_oe_hold_off: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (cs_high && s.lvl.cs_n) |=> ##1 !o_so_oe)
        else $error("output driven while deselected");

    chk_fault_update: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_core.op_done |=> s.write_erase_fault == $past(i_core.op_fault))
        else $error("fault flag not updated on completion");

    chk_abort_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_core.op_abort && !i_core.op_done)
        |=> $stable(s.write_erase_fault))
        else $error("abort changed the fault flag");

    chk_compare_result: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_core.comp_done |=> (s.comp == $past(i_core.comp_mismatch)
         && status_byte_one[flash_status_pkg::POS_COMPARE] == $past(i_core.comp_mismatch)))
        else $error("compare result not captured");

    // Field placement is checked at the load, where a misplaced bit cannot hide
    chk_density_code: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        load_one |=> s.shift[5:2] == DENSITY_CODE)
        else $error("density code not loaded into byte one");

    chk_protect_page: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        load_one |=> s.shift[1:0] == $past({i_core.protect, i_core.page_512}))
        else $error("protect or page size bit not loaded");

    chk_compare_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        load_one |=> s.shift[6] == $past(s.comp))
        else $error("compare bit not loaded into byte one");

    chk_fault_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        load_two |=> s.shift[5] == $past(s.write_erase_fault))
        else $error("fault bit not loaded into byte two");

    chk_reserved_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        load_two |=> {s.shift[6], s.shift[4:3]} == 3'h0)
        else $error("reserved bits of byte two loaded nonzero");

    chk_shift_order: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (byte_start && s.bit_cnt != 3'h0 && !cs_high && !cs_rise)
        |=> (o_so == $past(s.shift[6]) && o_so_oe))
        else $error("status bit not shifted out in order");

    chk_status_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (s.phase == flash_status_pkg::PH_STATUS && !sck_fall) |=> $stable(o_so))
        else $error("serial output moved without a clock fall");

    chk_idle_undriven: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s.phase == flash_status_pkg::PH_IDLE |=> !o_so_oe)
        else $error("output driven after returning to idle");

    chk_ignore_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s.phase == flash_status_pkg::PH_IGNORE |-> !o_so_oe)
        else $error("output driven after an unknown opcode");

    chk_opcode_reject: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (s.phase == flash_status_pkg::PH_OPCODE && sck_rise && s.bit_cnt == 3'h7
         && opcode_in != flash_status_pkg::OPCODE_READ_STATUS && !cs_rise && !cs_high)
        |=> s.phase == flash_status_pkg::PH_IGNORE)
        else $error("unknown opcode not ignored");

    chk_entry_sel: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        $rose(s.phase == flash_status_pkg::PH_STATUS) |-> !s.byte_sel)
        else $error("status read did not start with byte one");

    cov_status_read: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s.phase == flash_status_pkg::PH_OPCODE ##1 s.phase == flash_status_pkg::PH_STATUS);

    cov_second_pass: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        byte_start && s.bit_cnt == 3'h7 && s.byte_sel);

    cov_mid_byte_end: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        cs_rise && s.phase == flash_status_pkg::PH_STATUS && s.bit_cnt != 3'h0);

    cov_ready_rise: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s.phase == flash_status_pkg::PH_STATUS && $fell(i_core.busy));

    cov_opcode_reject: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s.phase == flash_status_pkg::PH_OPCODE ##1 s.phase == flash_status_pkg::PH_IGNORE);

endmodule // flash_status_readout

// ==== testbench/spi_host_model.sv ====
// Behavioural SPI host that polls the flash status word in mode 0
`timescale 1ns/1ps

module spi_host_model #(
    parameter int HALF = 8 // Clocks per SCK phase, well above the pin filter delay
) (
    input  wire logic                      i_clk, // Bench clock
    input  wire logic                      i_so,  // Resolved serial out wire
    output flash_status_pkg::spi_pins_type o_spi  // Pins toward the device
);
    initial o_spi = 3'h2;

    // Released data line toggles so a stale value can never look valid
    always @(negedge i_clk)
        if (o_spi.cs_n)
            o_spi.si <= ~o_spi.si;

    // ==========================================================
    // Frame tasks
    // ==========================================================
    task automatic select(input logic on);
        @(negedge i_clk);
        o_spi.sck = 1'h0;
        o_spi.cs_n = ~on;
        repeat (HALF) @(negedge i_clk);
    endtask

    task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int k = 0; k < n; k++)
        begin
            o_spi.si = tx[7-k];
            repeat (HALF) @(negedge i_clk);
            rx = {rx[6:0], i_so};
            o_spi.sck = 1'h1;
            repeat (HALF) @(negedge i_clk);
            o_spi.sck = 1'h0;
        end
    endtask
endmodule // spi_host_model

// ==== testbench/tb_flash_status_readout.sv ====
// Self-checking bench for the flash status readout block
`timescale 1ns/1ps

module tb_flash_status_readout;
    localparam logic [3:0] DENS = 4'ha; // Arbitrary capacity code for this run
    localparam logic [7:0] RD   = flash_status_pkg::OPCODE_READ_STATUS;

    logic                              i_clk_sys = 1'h0;
    logic                              i_rstn    = 1'h0;
    flash_status_pkg::spi_pins_type    spi;
    flash_status_pkg::core_status_type core;
    logic                              o_so;
    logic                              o_so_oe;
    logic [7:0]                        b_one;
    logic [7:0]                        b_two;
    wire                               so_wire = o_so_oe ? o_so : 1'bz;
    int                                fail_count  = 0;
    int                                checks_done = 0;
    int                                seed = 84;
    int                                cyc  = 0;
    logic                              m_comp  = 1'h0;
    logic                              m_fault = 1'h0;

    always #2 i_clk_sys = ~i_clk_sys;

    flash_status_readout #(.DENSITY_CODE(DENS)) flash_status_readout_i (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_spi(spi), .i_core(core),
        .o_so(o_so), .o_so_oe(o_so_oe),
        .o_status_byte_one(b_one), .o_status_byte_two(b_two));

    spi_host_model #(.HALF(8)) spi_host_model_i (
        .i_clk(i_clk_sys), .i_so(so_wire), .o_spi(spi));

    // ==========================================================
    // Reference model and checks
    // ==========================================================
    function automatic logic [7:0] exp_byte(input int k);
        if (k % 2 == 0)
            return {~core.busy, m_comp, DENS, core.protect, core.page_512};
        return {~core.busy, 1'h0, m_fault, 5'h00};
    endfunction

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Pulse fields: comp_done, comp_mismatch, op_done, op_fault, op_abort
    task automatic pulse(input logic [4:0] p);
        @(negedge i_clk_sys);
        core[4:0] = p;
        if (p[4])
            m_comp = p[3];
        if (p[2])
            m_fault = p[1]; // abort alone leaves the flag alone
        @(negedge i_clk_sys);
        core[4:0] = 5'h00;
    endtask

    task automatic frame(input int nbytes, input int tail, input logic [7:0] op);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] ex;
        spi_host_model_i.select(1'h1);
        spi_host_model_i.shift(8, op, hi);
        for (int k = 0; k < nbytes; k++)
        begin
            ex = exp_byte(k);
            spi_host_model_i.shift(4, 8'($random(seed)), hi);
            core.busy = 1'($random(seed));
            pulse(5'($random(seed)));
            spi_host_model_i.shift(4, 8'($random(seed)), lo);
            cmp({7'h00, o_so_oe}, {7'h00, op == RD}, "drive enable");
            if (op == RD)
                cmp({hi[3:0], lo[3:0]}, ex, "status byte");
        end
        spi_host_model_i.shift(tail, 8'($random(seed)), hi);
        spi_host_model_i.select(1'h0);
        cmp({7'h00, o_so_oe}, 8'h00, "released drive");
        cmp(b_one, exp_byte(0), "live byte one");
        cmp(b_two, exp_byte(1), "live byte two");
    endtask

    // Host keeps reading whole status bytes until ready reads 1; busy ends mid-poll
    task automatic poll(input int busy_bytes);
        logic [7:0] rx;
        int         n;
        n = 0;
        core.busy = 1'h1;
        spi_host_model_i.select(1'h1);
        spi_host_model_i.shift(8, RD, rx);
        rx = 8'h00;
        while (!rx[7] && n < busy_bytes + 2)
        begin
            if (n == busy_bytes)
                core.busy = 1'h0;
            spi_host_model_i.shift(8, 8'($random(seed)), rx);
            n++;
        end
        spi_host_model_i.select(1'h0);
        cmp(8'(n), 8'(busy_bytes + 1), "bytes polled until ready");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            close_out();
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        core = '0;
        repeat (2) @(negedge i_clk_sys);
        i_rstn = 1'h1;
        cmp({6'h00, o_so_oe, o_so}, 8'h00, "reset outputs");
        frame(4, 0, RD);
        $display("test wrap done");
        pulse(5'h06);
        pulse(5'h01);
        frame(2, 3, RD);
        pulse(5'h03);
        frame(2, 0, RD);
        $display("test abort done");
        for (int i = 0; i < 9; i++)
        begin
            core[7:5] = 3'($random(seed));
            frame(2 + i % 4, i % 8, (i == 4) ? RD ^ 8'h5a : RD);
            $display("test frame %0d done", i);
        end
        poll(3);
        $display("test poll done");
        pulse(5'h1e);
        cmp(b_two, exp_byte(1), "fault set before reset");
        i_rstn = 1'h0;
        repeat (2) @(negedge i_clk_sys);
        i_rstn = 1'h1;
        m_comp  = flash_status_pkg::RESET_COMPARE;
        m_fault = flash_status_pkg::RESET_FAULT;
        cmp({6'h00, o_so_oe, o_so}, 8'h00, "outputs after reset");
        cmp(b_one, exp_byte(0), "byte one after reset");
        cmp(b_two, exp_byte(1), "byte two after reset");
        frame(2, 1, RD);
        $display("test reset done");
        close_out();
    end
endmodule // tb_flash_status_readout
